// ===== verilog/txw_pkg.sv
// Shared constants and types for the wide transmit write port.
// Assumes a single 200 MHz clock shared by writer and buffer.
package txw_pkg;
  localparam int WORD_W = 64;
  localparam int MASK_W = 8;
  localparam int PART_N = 8;
  localparam int SEL_W = 3;
  localparam int LINE_W = 128;
  // Lines per partition in 32-bit mode; wide mode doubles it.
  localparam int NARROW_LINES = 4;
  localparam int WIDE_LINES = 2 * NARROW_LINES;
  localparam int PTR_W = $clog2(WIDE_LINES);
  localparam int MEM_LINES = PART_N * WIDE_LINES;
  localparam int MEM_AW = $clog2(MEM_LINES);
  localparam int FIFO_DEPTH = 16;
  localparam logic [MASK_W-1:0] MASK_FULL = 8'hFF;
  localparam logic [MASK_W-1:0] MASK_NONE = 8'h00;
  localparam logic [SEL_W-1:0] SEL_ZERO = 3'h0;
  // Entry carried through the FIFO: sel, start, end, mask, word.
  localparam int ENTRY_W = SEL_W + 2 + MASK_W + WORD_W;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic sop;
    logic eop;
    logic [MASK_W-1:0] mask;
    logic [WORD_W-1:0] word;
  } entry_s;

  // A legal mask is a contiguous run of ones from the top bit.
  function automatic logic mask_legal(input logic [MASK_W-1:0] m);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < MASK_W - 1; i++)
    begin
      if (m[i] && !m[i+1])
      begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : mask_legal
endpackage : txw_pkg

// ===== verilog/txw_if.sv
// Carrier joining the fabric writer and the buffer write port.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface txw_if;
  import txw_pkg::*;
  logic [SEL_W-1:0] partition_select;
  logic [WORD_W-1:0] tx_write_word;
  logic [MASK_W-1:0] byte_valid_mask;
  logic packet_start_flag;
  logic packet_end_flag;
  logic write_strobe;
  logic write_ready;
  modport writer (
    output partition_select, tx_write_word, byte_valid_mask,
    output packet_start_flag, packet_end_flag, write_strobe,
    input write_ready
  );
  modport buffer (
    input partition_select, tx_write_word, byte_valid_mask,
    input packet_start_flag, packet_end_flag, write_strobe,
    output write_ready
  );
endinterface : txw_if

// ===== verilog/txw_fifo.sv
// Parameterised valid/ready FIFO used in the write data path.
// Assumes one clock; output data comes from the storage array.
`timescale 1ns/1ps
module txw_fifo
  import txw_pkg::*;
#(
  parameter int WIDTH = ENTRY_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } ptr_s;
  ptr_s st_ff, nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic push, pop;

  assign in_ready = !((st_ff.wr[AW] != st_ff.rd[AW]) &&
                      (st_ff.wr[AW-1:0] == st_ff.rd[AW-1:0]));
  assign out_valid = (st_ff.wr != st_ff.rd);
  assign out_data = mem_ff[st_ff.rd[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.wr = st_ff.wr + 1'b1;
    end
    if (pop)
    begin
      nxt_st.rd = st_ff.rd + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Storage needs no reset; empty state hides stale entries.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_ff[st_ff.wr[AW-1:0]] <= in_data;
    end
  end
endmodule : txw_fifo

// ===== verilog/txw_buffer.sv
// Buffer end: partitioned transmit buffer memory, wide write side.
// Assumes the writer keeps two-write bursts and legal masks.
//
// Behaviour
// [R01] Eight partitions chosen by three-bit select.
// [R02] Wide-mode partitions twice the narrow depth.
// [R03] Several ports may share one partition.
// [R04] Writer pairs two words into one line.
// [R05] Writer issues two-write bursts unless end.
// [R06] Mask bit n qualifies byte n.
// [R07] Empty mask drops data, no write.
// [R08] Writer sends full masks except last.
// [R09] Full mask: whole word, end in byte eight.
// [R10] Partial mask is top-aligned run of ones.
// [R11] Start flag marks packet beginning.
// [R12] Start flag only on first line write.
// [R13] Capture word only when strobe high.
// [R14] End mark advances pointer to next line.
// [R15] Second write advances pointer, wrapping in partition.
`timescale 1ns/1ps
module txw_buffer
  import txw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  txw_if.buffer bus,
  input wire logic [MEM_AW-1:0] rd_line,
  output logic [LINE_W-1:0] rd_data,
  output logic [2*MASK_W-1:0] rd_mask,
  output logic [PART_N-1:0] line_start,
  output logic [PART_N-1:0] line_end,
  output logic [PART_N*PTR_W-1:0] wr_ptrs,
  output logic [PART_N-1:0] half_pending,
  output logic mask_error
);
  typedef struct packed {
    logic [PART_N-1:0][PTR_W-1:0] ptr;
    logic [PART_N-1:0] half;
    logic [PART_N-1:0] sop_seen;
    logic [PART_N-1:0] eop_seen;
    logic merr;
    logic [LINE_W-1:0] rdat;
    logic [2*MASK_W-1:0] rmsk;
  } state_s;
  state_s st_ff, nxt_st;
  localparam int LANE_W = WORD_W / MASK_W;
  logic [2*MASK_W-1:0][LANE_W-1:0] rd_lanes;
  logic [2*MASK_W-1:0] msk_ff [MEM_LINES];
  logic in_valid, out_valid;
  logic [ENTRY_W-1:0] out_raw;
  entry_s in_e, ent;
  logic take, do_wr;
  logic [MEM_AW-1:0] wa;

  assign in_valid = bus.write_strobe; // [R13]
  assign in_e = '{sel: bus.partition_select, sop: bus.packet_start_flag,
                  eop: bus.packet_end_flag, mask: bus.byte_valid_mask,
                  word: bus.tx_write_word};

  txw_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(in_valid),
    .in_ready(bus.write_ready),
    .in_data(in_e),
    .out_valid(out_valid),
    .out_ready(1'b1),
    .out_data(out_raw)
  );

  assign ent = entry_s'(out_raw);
  assign take = out_valid;
  assign do_wr = take && (ent.mask != MASK_NONE); // [R07]
  // Partition base plus line pointer; sharing ports simply reuse a sel.
  assign wa = {ent.sel, st_ff.ptr[ent.sel]}; // [R01] [R02] [R03]

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdat = rd_lanes;
    nxt_st.rmsk = msk_ff[rd_line];
    if (do_wr)
    begin
      if (!mask_legal(ent.mask))
      begin
        nxt_st.merr = 1'b1; // [R10]
      end
      if (ent.sop)
      begin
        nxt_st.sop_seen[ent.sel] = 1'b1; // [R11]
      end
      nxt_st.eop_seen[ent.sel] = ent.eop;
      // End on either half, or the second half, closes the line.
      if (ent.eop || st_ff.half[ent.sel])
      begin
        nxt_st.ptr[ent.sel] = st_ff.ptr[ent.sel] + 1'b1; // [R14] [R15]
        nxt_st.half[ent.sel] = 1'b0;
      end
      else
      begin
        nxt_st.half[ent.sel] = 1'b1; // [R04]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Each byte lane keeps its own array, so a lane whose mask bit is clear
  // keeps its old contents rather than taking bytes the writer disowned.
  for (genvar h = 0; h < 2; h++)
  begin : g_half
    for (genvar b = 0; b < MASK_W; b++)
    begin : g_lane
      logic [LANE_W-1:0] lane_ff [MEM_LINES];
      logic lane_we;
      // First half of a line lands in the upper word.
      assign lane_we = do_wr && ent.mask[b] &&
                       (st_ff.half[ent.sel] == (h == 0)); // [R06]
      always_ff @(posedge clk)
      begin
        if (lane_we)
        begin
          lane_ff[wa] <= ent.word[LANE_W*b +: LANE_W];
        end
      end
      assign rd_lanes[MASK_W*h+b] = lane_ff[rd_line];
    end : g_lane
  end : g_half

  // First half lands in the upper 64 bits of the line.
  always_ff @(posedge clk)
  begin
    if (do_wr)
    begin
      if (st_ff.half[ent.sel])
      begin
        msk_ff[wa][MASK_W-1:0] <= ent.mask; // [R09]
      end
      else
      begin
        msk_ff[wa] <= {ent.mask, MASK_NONE};
      end
    end
  end

  assign rd_data = st_ff.rdat;
  assign rd_mask = st_ff.rmsk;
  assign line_start = st_ff.sop_seen;
  assign line_end = st_ff.eop_seen;
  assign wr_ptrs = st_ff.ptr;
  assign half_pending = st_ff.half;
  assign mask_error = st_ff.merr;
endmodule : txw_buffer

// ===== verilog/txw_writer.sv
// Writer end: fabric logic sending packets as paired 64-bit writes.
// Assumes the user side holds a word until word_ready.
`timescale 1ns/1ps
module txw_writer
  import txw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  txw_if.writer bus,
  input wire logic word_valid,
  output logic word_ready,
  input wire logic [SEL_W-1:0] word_sel,
  input wire logic [WORD_W-1:0] word_data,
  input wire logic [MASK_W-1:0] word_mask,
  input wire logic word_first,
  input wire logic word_last
);
  typedef struct packed {
    logic [PART_N-1:0] half;
  } state_s;
  state_s st_ff, nxt_st;
  logic fire;
  logic [MASK_W-1:0] mask_out;

  assign word_ready = bus.write_ready;
  assign fire = word_valid && bus.write_ready;
  assign bus.write_strobe = fire;
  assign bus.partition_select = word_sel;
  assign bus.tx_write_word = word_data;
  // Non-final words are forced to a full mask.
  assign mask_out = word_last ? word_mask : MASK_FULL; // [R08]
  assign bus.byte_valid_mask = mask_out;
  // Start only on the first half of a line.
  assign bus.packet_start_flag = word_first && !st_ff.half[word_sel]; // [R12]
  assign bus.packet_end_flag = word_last; // [R05]

  always_comb
  begin
    nxt_st = st_ff;
    // The buffer drops empty masks, so they must not move the line half.
    if (fire && mask_out != MASK_NONE) // [R07]
    begin
      nxt_st.half[word_sel] = !word_last && !st_ff.half[word_sel]; // [R04]
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
endmodule : txw_writer

// ===== bench/txw_properties.sv
// Checker for the wire between writer and buffer.
// Assumes the interface signals arrive as plain inputs.
`timescale 1ns/1ps
module txw_properties
  import txw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [SEL_W-1:0] partition_select,
  input wire logic [WORD_W-1:0] tx_write_word,
  input wire logic [MASK_W-1:0] byte_valid_mask,
  input wire logic packet_start_flag,
  input wire logic packet_end_flag,
  input wire logic write_strobe,
  input wire logic write_ready
);
  logic half_ff;
  logic open_ff;
  wire logic take = write_strobe && write_ready &&
                    byte_valid_mask != MASK_NONE;
  // Empty masks are dropped, so they must not move the line tracking.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_ff <= 1'b0;
      open_ff <= 1'b0;
    end
    else if (take)
    begin
      half_ff <= !packet_end_flag && !half_ff;
      open_ff <= !packet_end_flag;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_line_open;
    take && !half_ff && !packet_end_flag;
  endsequence
  a_mask_top_aligned: assert property (
    write_strobe |-> ((~byte_valid_mask) & ((~byte_valid_mask) + 8'h01))
    == MASK_NONE)
    else $error("mask not top aligned");
  a_full_unless_end: assert property (
    take && !packet_end_flag |-> byte_valid_mask == MASK_FULL)
    else $error("partial mask without end");
  a_start_first_half: assert property (
    take && packet_start_flag |-> !half_ff)
    else $error("start on second half");
  a_start_new_pkt: assert property (
    take && packet_start_flag |-> !open_ff)
    else $error("start inside packet");
  a_body_in_pkt: assert property (
    take && !packet_start_flag |-> open_ff)
    else $error("word outside packet");
  a_pair_same_sel: assert property (
    s_line_open ##1 take |-> partition_select == $past(partition_select))
    else $error("line halves in two partitions");
  a_second_follows: assert property (
    s_line_open |-> ##[1:4] take)
    else $error("line left half written");
  a_ready_high: assert property (
    write_ready)
    else $error("write refused");
endmodule : txw_properties

// ===== bench/testbench.sv
// Bench joining writer and buffer through the shared carrier.
// Assumes the buffer drains every cycle and never stalls.
`timescale 1ns/1ps
module testbench;
  import txw_pkg::*;
  logic clk = 0, rst_n, wv = 0, wr, wf = 0, wl = 0, merr;
  logic [SEL_W-1:0] ws = '0;
  logic [WORD_W-1:0] wd = '0, hi;
  logic [MASK_W-1:0] wm = '0;
  logic [PART_N*PTR_W-1:0] ptrs, ev = '0, seen = '0;
  logic [PART_N-1:0] half, hm = '0, ls, le;
  logic [MEM_AW-1:0] rl = '0;
  logic [LINE_W-1:0] rd;
  logic [2*MASK_W-1:0] rm;
  logic [127:0] q[$];
  int n_errors = 0, n_tests = 0;
  integer seed = 32'h710D224E;
  txw_if bus();
  txw_writer i_txw_writer (.clk(clk), .rst_n(rst_n), .bus(bus),
    .word_valid(wv), .word_ready(wr), .word_sel(ws), .word_data(wd),
    .word_mask(wm), .word_first(wf), .word_last(wl));
  txw_buffer i_txw_buffer (.clk(clk), .rst_n(rst_n), .bus(bus),
    .rd_line(rl), .rd_data(rd), .rd_mask(rm), .line_start(ls),
    .line_end(le), .wr_ptrs(ptrs), .half_pending(half),
    .mask_error(merr));
  txw_properties i_txw_properties (.clk(clk), .rst_n(rst_n),
    .partition_select(bus.partition_select),
    .tx_write_word(bus.tx_write_word),
    .byte_valid_mask(bus.byte_valid_mask),
    .packet_start_flag(bus.packet_start_flag),
    .packet_end_flag(bus.packet_end_flag),
    .write_strobe(bus.write_strobe), .write_ready(bus.write_ready));
  always #2.5 clk = ~clk;
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task summarize;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task put(input logic [SEL_W-1:0] s, input logic [MASK_W-1:0] m,
    input logic f, input logic l);
    ws <= s;
    wm <= m;
    wf <= f;
    wl <= l;
    wv <= 1'b1;
    wd <= {$random(seed), $random(seed)};
    @(negedge clk);
    while (!wr) @(negedge clk);
    @(posedge clk);
    if (m != MASK_NONE && (l || hm[s]))
    begin
      ev[s*PTR_W +: PTR_W] = ev[s*PTR_W +: PTR_W] + 3'h1;
      q.push_back(ev);
      hm[s] = 1'b0;
    end
    else if (m != MASK_NONE)
      hm[s] = 1'b1;
  endtask : put
  task pkt(input logic [SEL_W-1:0] s, input int n,
    input logic [MASK_W-1:0] m);
    for (int i = 0; i < n; i++)
      put(s, (i == n - 1) ? m : MASK_FULL, i == 0, i == n - 1);
  endtask : pkt
  // One line through the internal queue and back out of the read port.
  task read_test;
    rl <= {3'h5, ev[5*PTR_W +: PTR_W]};
    put(3'h5, MASK_FULL, 1'b1, 1'b0);
    hi = wd;
    put(3'h5, 8'hC0, 1'b0, 1'b1);
    wv <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(rd[LINE_W-1:WORD_W], hi);
    check(rd[WORD_W-1:WORD_W-16], wd[WORD_W-1:WORD_W-16]);
    check(rm, {MASK_FULL, 8'hC0});
    check({ls[5], le[5]}, 2'b11);
  endtask : read_test
  // Pointer moves show one clock after the push, so compare off-edge.
  always @(negedge clk)
  begin
    if (rst_n && ptrs !== seen)
    begin
      seen = ptrs;
      check(seen, q.size() ? q.pop_front() : ~seen);
    end
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    n_errors++;
    summarize;
  end
  initial
  begin
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check({ptrs, half, merr, ls, le}, '0);
    $display("reset test done");
    @(posedge clk);
    for (int s = 0; s < PART_N; s++)
      pkt(s[SEL_W-1:0], s + 1, MASK_FULL << s);
    pkt(SEL_ZERO, 20, MASK_FULL);
    put(3'h3, MASK_NONE, 1'b0, 1'b1);
    pkt(3'h3, 2, MASK_FULL);
    wv <= 1'b0;
    repeat (6) @(posedge clk);
    check(q.size(), 0);
    check(half, '0);
    check(merr, 1'b0);
    $display("packet test done");
    @(posedge clk);
    read_test;
    $display("read test done");
    repeat (4) @(posedge clk);
    check(q.size(), 0);
    summarize;
  end
endmodule : testbench
